/* File: sar_pkg.sv */
// Package: shared constants for the converter control and serial readout block
package sar_pkg;
    // ***************************************************************
    // Result format
    // ***************************************************************
    localparam int RESULT_BITS = 18;
    localparam int BIT_CNT_W = 5;
    localparam logic [4:0] LAST_BIT = 5'h11;
    localparam logic [17:0] FULL_SCALE_HALF = 18'h20000;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 18;

    // ***************************************************************
    // Timing
    // ***************************************************************
    localparam int CLK_PERIOD_NS = 50;
    // Internal oscillator: one successive approximation step per tick
    localparam int OSC_DIV = 2;
    localparam logic [1:0] OSC_DIV_LAST = 2'(OSC_DIV - 1);
    localparam int CONV_TIME_MIN_NS = 1000;
    localparam int CONV_CYCLES = (CONV_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ***************************************************************
    // Converter states
    // ***************************************************************
    typedef enum logic [1:0]
    {
        SAR_NAP = 2'b00,
        SAR_CONVERT = 2'b01,
        SAR_DONE = 2'b11
    } sar_state_e;
endpackage : sar_pkg

/* File: sar_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sar_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign o_in_ready = (count_q != (AW+1)'(DEPTH));
    assign o_out_valid = (count_q != '0);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem_q[rd_q];

    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= AW'((wr_q == AW'(DEPTH - 1)) ? 0 : wr_q + 1'b1);
            end
            if (pop)
            begin
                rd_q <= AW'((rd_q == AW'(DEPTH - 1)) ? 0 : rd_q + 1'b1);
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : sar_fifo

/* File: sar_readout.sv */
// Converter control: trigger, successive approximation, busy, nap and serial readout
//
// Operation
// - Rising convert_trigger edge wakes device from nap and starts a conversion.
// - Cascade select low: shared pin only enables or disables serial output.
// - Cascade select high: shared pin is serial chain data input.
// - Busy rises when conversion begins, falls when it completes.
// - Enabled output shifts one bit per rising shift-clock edge while napping, MSB first.
// - Results are two's complement over the bipolar full scale.
// - Eighteen-step successive approximation down to one part in 262144.
// - Result is ready for readout as conversion ends, no pipeline delay.
// - Conversion is timed by an internal oscillator, no host clock.
// - Device naps automatically between conversions.
// - Between conversions the sample tracks the input until the next trigger.
// - Normal mode drives output only while read enable is low.
`timescale 1ns/1ps
module sar_readout
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Analog front end model: unsigned offset-binary sample of the input
    input wire logic [17:0] i_analog_level,
    output logic o_sample_track,
    // Host pins
    input wire logic i_convert_trigger,
    input wire logic i_cascade_select,
    input wire logic i_read_enable_or_cascade_in,
    input wire logic i_shift_clk,
    output logic o_busy,
    output logic o_nap,
    output logic o_serial_result_out,
    output logic o_serial_result_out_oe,
    // Result stream tap
    output logic o_result_valid,
    output logic [17:0] o_result_data,
    input wire logic i_result_ready
);
    // ***************************************************************
    // Pin synchronisers
    // ***************************************************************
    logic [1:0] cnv_sync_q;
    logic [1:0] sel_sync_q;
    logic [1:0] rdl_sync_q;
    logic [1:0] sck_sync_q;
    logic cnv_prev_q;
    logic sck_prev_q;
    logic cnv_rise;
    logic sck_rise;

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            cnv_sync_q <= '0;
            sel_sync_q <= '0;
            rdl_sync_q <= 2'h3;
            sck_sync_q <= '0;
            cnv_prev_q <= 1'b0;
            sck_prev_q <= 1'b0;
        end
        else
        begin
            cnv_sync_q <= {cnv_sync_q[0], i_convert_trigger};
            sel_sync_q <= {sel_sync_q[0], i_cascade_select};
            rdl_sync_q <= {rdl_sync_q[0], i_read_enable_or_cascade_in};
            sck_sync_q <= {sck_sync_q[0], i_shift_clk};
            cnv_prev_q <= cnv_sync_q[1];
            sck_prev_q <= sck_sync_q[1];
        end
    end

    // Edge detectors reset low, the idle level of both pins, so no false edge follows reset
    assign cnv_rise = cnv_sync_q[1] && !cnv_prev_q;
    assign sck_rise = sck_sync_q[1] && !sck_prev_q;

    // ***************************************************************
    // Internal conversion oscillator
    // ***************************************************************
    sar_pkg::sar_state_e state_q;
    sar_pkg::sar_state_e state_d;
    logic [1:0] osc_cnt_q;
    logic osc_tick;

    // Oscillator runs only while converting, so napping costs no toggles
    always_ff @(posedge i_clk)
    begin
        if (i_reset || state_q != sar_pkg::SAR_CONVERT)
        begin
            osc_cnt_q <= '0;
        end
        else
        begin
            osc_cnt_q <= (osc_cnt_q == sar_pkg::OSC_DIV_LAST) ? 2'h0 : osc_cnt_q + 2'h1;
        end
    end

    // One approximation step per tick; the tick rate sets the conversion time
    assign osc_tick = (state_q == sar_pkg::SAR_CONVERT) && (osc_cnt_q == sar_pkg::OSC_DIV_LAST);

    // ***************************************************************
    // Conversion sequencer
    // ***************************************************************
    logic busy_q;
    logic nap_q;
    logic track_q;
    logic [17:0] sample_q;
    logic [17:0] trial_q;
    logic [17:0] approx_q;
    logic [4:0] step_q;
    logic [17:0] result_q;
    logic conv_done;
    logic [17:0] test_val;

    assign test_val = approx_q | trial_q;
    assign conv_done = osc_tick && (step_q == sar_pkg::LAST_BIT);

    // ***************************************************************
    // Next state and status pins
    // ***************************************************************
    // Triggers in the convert and done states are ignored
    function automatic sar_pkg::sar_state_e sar_next(input sar_pkg::sar_state_e cur, input logic start,
                                                     input logic finish);
        sar_pkg::sar_state_e nxt;
        nxt = cur;
        unique case (cur)
            sar_pkg::SAR_NAP:
            begin
                if (start)
                begin
                    nxt = sar_pkg::SAR_CONVERT;
                end
            end
            sar_pkg::SAR_CONVERT:
            begin
                if (finish)
                begin
                    nxt = sar_pkg::SAR_DONE;
                end
            end
            sar_pkg::SAR_DONE:
            begin
                nxt = sar_pkg::SAR_NAP;
            end
            default:
            begin
                nxt = sar_pkg::SAR_NAP;
            end
        endcase
        return nxt;
    endfunction : sar_next

    assign state_d = sar_next(state_q, cnv_rise, conv_done);

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            state_q <= sar_pkg::SAR_NAP;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Status pins load the decode of the coming state, so they move on the same edge as the state
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            busy_q <= 1'b0;
            nap_q <= 1'b1;
            track_q <= 1'b1;
        end
        else
        begin
            busy_q <= (state_d == sar_pkg::SAR_CONVERT);
            nap_q <= (state_d == sar_pkg::SAR_NAP);
            track_q <= (state_d != sar_pkg::SAR_CONVERT);
        end
    end

    // Sample follows the input while idle and freezes on the trigger
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            sample_q <= '0;
        end
        else if (state_q != sar_pkg::SAR_CONVERT)
        begin
            sample_q <= i_analog_level;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            trial_q <= '0;
            approx_q <= '0;
            step_q <= '0;
        end
        // The trigger arms the first trial bit at half scale
        else if (state_q == sar_pkg::SAR_NAP && cnv_rise)
        begin
            trial_q <= sar_pkg::FULL_SCALE_HALF;
            approx_q <= '0;
            step_q <= '0;
        end
        else if (osc_tick)
        begin
            // Keep the trial bit when the held sample reaches the test value
            if (sample_q >= test_val)
            begin
                approx_q <= test_val;
            end
            trial_q <= trial_q >> 1;
            step_q <= step_q + 5'h01;
        end
    end

    // Offset binary to two's complement by inverting the MSB
    // The last step is folded in here so the word is complete in the done cycle
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            result_q <= '0;
        end
        else if (conv_done)
        begin
            result_q <= (sample_q >= test_val) ? (test_val ^ sar_pkg::FULL_SCALE_HALF)
                                               : (approx_q ^ sar_pkg::FULL_SCALE_HALF);
        end
    end

    assign o_busy = busy_q;
    assign o_nap = nap_q;
    assign o_sample_track = track_q;

    // ***************************************************************
    // Result FIFO toward the tap
    // ***************************************************************
    logic result_push;

    // Each finished result is offered to the tap in the done cycle
    assign result_push = (state_q == sar_pkg::SAR_DONE);

    sar_fifo #(
        .WIDTH(sar_pkg::FIFO_WIDTH),
        .DEPTH(sar_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_in_valid(result_push),
        .i_in_data(result_q),
        .o_in_ready(),
        .o_out_valid(o_result_valid),
        .o_out_data(o_result_data),
        .i_out_ready(i_result_ready)
    );

    // ***************************************************************
    // Serial shifter
    // ***************************************************************
    logic [17:0] shift_q;
    logic out_q;
    logic chain_mode;
    logic out_en;

    // Mode follows the synchronised select pin, so a change takes hold two cycles late
    assign chain_mode = sel_sync_q[1];
    // Normal mode: active-low read enable; chain mode always drives
    assign out_en = chain_mode || !rdl_sync_q[1];

    // Result loads on completion; a full tap FIFO drops the copy, not the readout
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            shift_q <= '0;
            out_q <= 1'b0;
        end
        else if (state_q == sar_pkg::SAR_DONE)
        begin
            shift_q <= result_q;
            out_q <= result_q[17];
        end
        else if (sck_rise && out_en && state_q == sar_pkg::SAR_NAP)
        begin
            // Bit 17 is already on the pin, so the next is bit 16; chain bits reach the pin after 18 edges
            out_q <= shift_q[16];
            shift_q <= {shift_q[16:0], chain_mode ? rdl_sync_q[1] : 1'b0};
        end
    end

    assign o_serial_result_out = out_q;
    assign o_serial_result_out_oe = out_en;
endmodule : sar_readout

/* File: sar_readout_sva.sv */
// Checker: timing relations at the converter control ports
`timescale 1ns/1ps
module sar_readout_sva
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Host pins
    input wire logic i_convert_trigger,
    input wire logic i_cascade_select,
    input wire logic i_read_enable_or_cascade_in,
    // Status and output enable
    input wire logic o_busy,
    input wire logic o_nap,
    input wire logic o_sample_track,
    input wire logic o_serial_result_out_oe,
    input wire logic o_result_valid
);
    localparam int BUSY_CYCLES = sar_pkg::RESULT_BITS * sar_pkg::OSC_DIV;
    logic [7:0] busy_cnt_q;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // Length of the current busy run
    always_ff @(posedge i_clk)
    begin
        if (i_reset || !o_busy)
            busy_cnt_q <= 8'h00;
        else
            busy_cnt_q <= busy_cnt_q + 8'h01;
    end

    chk_edge_starts_busy: assert property ($rose(i_convert_trigger) && o_nap |-> ##[1:5] o_busy)
        else $error("busy missing after convert edge");
    chk_busy_run_length: assert property ($fell(o_busy) |-> busy_cnt_q == BUSY_CYCLES)
        else $error("busy run length wrong");
    chk_nap_after_done: assert property ($fell(o_busy) |-> ##1 o_nap)
        else $error("no nap after conversion");
    chk_busy_holds_sample: assert property (o_busy |-> !o_nap && !o_sample_track)
        else $error("tracking or napping while busy");
    chk_nap_tracks_input: assert property (o_nap |-> o_sample_track)
        else $error("not tracking while napping");
    chk_result_at_end: assert property ($fell(o_busy) |-> ##[0:2] o_result_valid)
        else $error("result not offered at end");
    chk_normal_oe_off: assert property ((!i_cascade_select && i_read_enable_or_cascade_in)[*5]
        |-> !o_serial_result_out_oe)
        else $error("output driven while read disabled");
    chk_normal_oe_on: assert property ((!i_cascade_select && !i_read_enable_or_cascade_in)[*5]
        |-> o_serial_result_out_oe)
        else $error("output not driven while read enabled");
    chk_chain_oe_on: assert property (i_cascade_select[*5] |-> o_serial_result_out_oe)
        else $error("output not driven in chain mode");
endmodule : sar_readout_sva

bind sar_readout sar_readout_sva chk (.i_clk(i_clk), .i_reset(i_reset), .i_convert_trigger(i_convert_trigger),
    .i_cascade_select(i_cascade_select), .i_read_enable_or_cascade_in(i_read_enable_or_cascade_in),
    .o_busy(o_busy), .o_nap(o_nap), .o_sample_track(o_sample_track),
    .o_serial_result_out_oe(o_serial_result_out_oe), .o_result_valid(o_result_valid));

/* File: sar_host_model.sv */
// Host controller model: convert trigger, shift clock and shared pin
`timescale 1ns/1ps
module sar_host_model
(
    // Clock
    input wire logic i_clk,
    // Device pins
    input wire logic i_busy,
    input wire logic i_sout,
    output logic o_convert_trigger,
    output logic o_shift_clk,
    output logic o_shared_pin
);
    initial
    begin
        o_convert_trigger = 1'b0;
        o_shift_clk = 1'b0;
        o_shared_pin = 1'b1;
    end

    // Shift clock stays low from the trigger until the result is out
    task automatic convert(output bit ok);
        int n;
        repeat (40) @(posedge i_clk);
        o_convert_trigger <= 1'b1;
        repeat (2) @(posedge i_clk);
        o_convert_trigger <= 1'b0;
        // Busy is polled on the falling edge, clear of the edge that moves it
        for (n = 0; n < 10 && i_busy !== 1'b1; n++)
            @(negedge i_clk);
        ok = (i_busy === 1'b1);
        for (n = 0; n < 60 && i_busy !== 1'b0; n++)
            @(negedge i_clk);
        ok = ok && (i_busy === 1'b0);
    endtask : convert

    // First bit is out before any edge; slow phases outlast the pin synchronisers
    task automatic read(input int nbits, input logic [35:0] pins, output logic [35:0] got);
        int k;
        got = '0;
        @(posedge i_clk);
        o_shared_pin <= pins[0];
        repeat (5) @(posedge i_clk);
        @(negedge i_clk);
        got = {got[34:0], i_sout};
        for (k = 1; k < nbits; k++)
        begin
            @(posedge i_clk);
            o_shift_clk <= 1'b1;
            repeat (3) @(posedge i_clk);
            @(negedge i_clk);
            got = {got[34:0], i_sout};
            @(posedge i_clk);
            o_shift_clk <= 1'b0;
            o_shared_pin <= pins[k];
            repeat (3) @(posedge i_clk);
        end
        o_shared_pin <= 1'b1;
    endtask : read
endmodule : sar_host_model

/* File: testbench.sv */
// Testbench: conversions, normal and chain readout, result FIFO
`timescale 1ns/1ps
module testbench;
    logic i_clk, i_reset, i_cascade_select, i_result_ready, o_result_valid;
    logic trig, sck, pin, busy, nap, track, sout, oe;
    logic [17:0] i_analog_level, o_result_data;
    logic [17:0] exp_q[$];
    int failures, checks;

    sar_readout dut (.i_clk(i_clk), .i_reset(i_reset), .i_analog_level(i_analog_level), .o_sample_track(track),
        .i_convert_trigger(trig), .i_cascade_select(i_cascade_select), .i_read_enable_or_cascade_in(pin),
        .i_shift_clk(sck), .o_busy(busy), .o_nap(nap), .o_serial_result_out(sout), .o_serial_result_out_oe(oe),
        .o_result_valid(o_result_valid), .o_result_data(o_result_data), .i_result_ready(i_result_ready));
    sar_host_model host (.i_clk(i_clk), .i_busy(busy), .i_sout(sout), .o_convert_trigger(trig),
        .o_shift_clk(sck), .o_shared_pin(pin));

    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    function automatic logic [17:0] code_of(input logic [17:0] level);
        return level ^ sar_pkg::FULL_SCALE_HALF;
    endfunction : code_of

    task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    initial
    begin
        logic [17:0] lvl;
        logic [16:0] pat;
        logic [35:0] pins, got, exp;
        bit ok, chain;
        int i, j;
        i_reset = 1'b1;
        i_analog_level = '0;
        i_cascade_select = 1'b0;
        i_result_ready = 1'b0;
        void'($urandom(65));
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        // Twelve results against an eight-deep tap that is never drained here
        for (i = 0; i < 12; i++)
        begin
            lvl = (i == 0) ? 18'h00000 : (i == 1) ? 18'h3FFFF : (i == 2) ? 18'h20000 : 18'($urandom());
            chain = (i % 3 == 2);
            pat = 17'($urandom());
            i_analog_level <= lvl;
            i_cascade_select <= chain;
            host.convert(ok);
            check("conversion", 36'h1, {35'h0, ok});
            if (!ok)
                report_and_stop();
            if (exp_q.size() < sar_pkg::FIFO_DEPTH)
                exp_q.push_back(code_of(lvl));
            if (i == 4)
            begin
                host.read(5, '1, got);
                check("oe", 36'h0, {35'h0, oe});
            end
            // Chain bits enter while the own word shifts out and follow it after 18 edges
            exp = chain ? {code_of(lvl), 18'h0} : {18'h0, code_of(lvl)};
            for (j = 0; j < 36; j++)
                pins[j] = chain ? pat[j % 17] : 1'b0;
            for (j = 0; j < 18 && chain; j++)
                exp[17 - j] = pins[j];
            host.read(chain ? 36 : 18, pins, got);
            check("serial word", exp, got);
        end
        for (i = 0; i < sar_pkg::FIFO_DEPTH; i++)
        begin
            @(posedge i_clk);
            check("fifo valid", 36'h1, {35'h0, o_result_valid});
            check("fifo word", {18'h0, exp_q[i]}, {18'h0, o_result_data});
            i_result_ready <= 1'b1;
            @(posedge i_clk);
            i_result_ready <= 1'b0;
        end
        @(posedge i_clk);
        check("fifo empty", 36'h0, {35'h0, o_result_valid});
        report_and_stop();
    end
endmodule : testbench
